// file: sram_cmd_pkg.sv
// constants, command and mode types for the sync sram command and burst block
// assumes a single core clock; mode, sleep and output enable pins arrive from outside and are synchronised in the core
package sram_cmd_pkg;

  localparam int ADDR_W = 16;
  localparam int LANES = 4;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int SLEEP_CYC = 2;
  localparam int PIPE_LAT = 2;
  localparam int FLOW_LAT = 1;
  localparam logic [1:0] SYNC_ONES = 2'h3;
  localparam logic [1:0] SYNC_ZERO = 2'h0;

  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_READ = 2'h1,
    OP_WRITE = 2'h3,
    OP_DESEL = 2'h2
  } op_e;

  typedef struct packed {
    logic hold_n;
    logic step_or_load;
    logic store_n;
    logic [LANES-1:0] byte_write_n;
    logic select_one_n;
    logic chip_sel2;
    logic select_three_n;
  } cmd_s;

  typedef struct packed {
    logic valid;
    logic is_write;
    logic drive;
    logic [LANES-1:0] lanes;
    logic [ADDR_W-1:0] addr;
  } slot_s;

endpackage

// file: sync_sram_command_burst.sv
// command decoder, burst counter, memory array and data pipeline of a sync sram
// assumes host commands on core_clk_i; mode pins, sleep and output enable arrive asynchronously
`timescale 1ns/100ps
module sync_sram_command_burst #(
  parameter int ADDR_W = sram_cmd_pkg::ADDR_W,
  parameter int DEPTH = 1 << ADDR_W
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire sram_cmd_pkg::cmd_s cmd_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic output_on_n_i,
  input wire logic linear_order_n_i,
  input wire logic flowthru_n_i,
  input wire logic drive_strength_sel_i,
  input wire logic sleep_req_i,
  input wire logic [sram_cmd_pkg::DATA_W-1:0] data_in_i,
  output logic [sram_cmd_pkg::DATA_W-1:0] data_out_o,
  output logic data_oe_o,
  output logic high_drive_o,
  output logic asleep_o,
  output logic [ADDR_W-1:0] cur_addr_o
);

  localparam int LANES = sram_cmd_pkg::LANES;
  localparam int LANE_W = sram_cmd_pkg::LANE_W;
  localparam int DATA_W = sram_cmd_pkg::DATA_W;
  localparam int BURST_W = sram_cmd_pkg::BURST_W;

  // async pins: three stages, a change counts once stages two and three agree
  logic [2:0] oe_n_sr, lin_n_sr, ft_n_sr, zq_sr, zz_sr;
  logic oe_n, lin_n, ft_n, zq, zz;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_n_sr <= 3'h7;
      lin_n_sr <= 3'h0;
      ft_n_sr <= 3'h7;     // pull-up default: pipeline
      zq_sr <= 3'h7;       // pull-up default: low drive
      zz_sr <= 3'h0;       // pull-down default: awake
    end else begin
      oe_n_sr <= {oe_n_sr[1:0], output_on_n_i};
      lin_n_sr <= {lin_n_sr[1:0], linear_order_n_i};
      ft_n_sr <= {ft_n_sr[1:0], flowthru_n_i};
      zq_sr <= {zq_sr[1:0], drive_strength_sel_i};
      zz_sr <= {zz_sr[1:0], sleep_req_i};
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_n <= 1'b1;
      lin_n <= 1'b0;
      ft_n <= 1'b1;
      zq <= 1'b1;
      zz <= 1'b0;
    end else begin
      if (oe_n_sr[1] == oe_n_sr[2]) oe_n <= oe_n_sr[2];
      if (lin_n_sr[1] == lin_n_sr[2]) lin_n <= lin_n_sr[2];
      if (ft_n_sr[1] == ft_n_sr[2]) ft_n <= ft_n_sr[2];
      if (zq_sr[1] == zq_sr[2]) zq <= zq_sr[2];
      if (zz_sr[1] == zz_sr[2]) zz <= zz_sr[2];
    end
  end

  assign high_drive_o = ~zq;

  // sleep entry and exit, each after a fixed count of cycles
  logic [1:0] sleep_cnt;
  logic asleep;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_cnt <= 2'h0;
      asleep <= 1'b0;
    end else if (zz != asleep) begin
      if (sleep_cnt == 2'(sram_cmd_pkg::SLEEP_CYC - 1)) begin
        asleep <= zz;
        sleep_cnt <= 2'h0;
      end else begin
        sleep_cnt <= sleep_cnt + 2'h1;
      end
    end else begin
      sleep_cnt <= 2'h0;
    end
  end
  assign asleep_o = asleep;

  // decode; sleep blocks commands like a held clock, keeping internal state but clearing the drive flag
  logic run, sel_all, do_load, do_step;
  sram_cmd_pkg::op_e op;
  assign run = !cmd_i.hold_n && !asleep;
  assign sel_all = !cmd_i.select_one_n && cmd_i.chip_sel2 && !cmd_i.select_three_n;
  assign do_load = run && !cmd_i.step_or_load && sel_all;
  // only a live read or write burst may continue; idle and deselect never step
  assign do_step = run && cmd_i.step_or_load &&
    (op == sram_cmd_pkg::OP_READ || op == sram_cmd_pkg::OP_WRITE);

  // burst state: start address, access index and order
  logic [ADDR_W-1:0] base;
  logic [BURST_W-1:0] idx;
  logic [BURST_W-1:0] next_low;
  logic [BURST_W-1:0] nidx;
  assign nidx = idx + 2'h1; // wraps after four accesses
  always_comb begin
    if (lin_n) next_low = base[BURST_W-1:0] ^ nidx;
    else next_low = base[BURST_W-1:0] + nidx;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      op <= sram_cmd_pkg::OP_IDLE;
      base <= '0;
      idx <= '0;
      cur_addr_o <= '0;
    end else if (run) begin
      if (!cmd_i.step_or_load) begin
        if (!sel_all) begin
          op <= sram_cmd_pkg::OP_DESEL;
        end else begin
          op <= cmd_i.store_n ? sram_cmd_pkg::OP_READ : sram_cmd_pkg::OP_WRITE;
          base <= addr_i;
          idx <= '0;
          cur_addr_o <= addr_i;
        end
      end else if (op == sram_cmd_pkg::OP_READ || op == sram_cmd_pkg::OP_WRITE) begin
        idx <= nidx;
        cur_addr_o <= {base[ADDR_W-1:BURST_W], next_low};
      end
      // continue after deselect leaves op as deselect
    end
  end

  // one access slot per taken edge; writes apply and reads drive at the latency end
  logic access_now;
  logic is_wr_now;
  logic [ADDR_W-1:0] acc_addr;
  logic [LANES-1:0] lanes_now;
  assign is_wr_now = do_load ? !cmd_i.store_n : (op == sram_cmd_pkg::OP_WRITE);
  assign lanes_now = is_wr_now ? ~cmd_i.byte_write_n : '0; // none active is a no-op
  assign access_now = do_load || do_step;
  assign acc_addr = do_load ? addr_i : {base[ADDR_W-1:BURST_W], next_low};

  sram_cmd_pkg::slot_s s1, s2;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1 <= '0;
      s2 <= '0;
    end else if (run) begin
      s1.valid <= access_now;
      s1.is_write <= is_wr_now;
      s1.drive <= access_now && !is_wr_now && !oe_n; // dummy read when disabled
      s1.lanes <= access_now ? lanes_now : '0;
      s1.addr <= acc_addr;
      s2 <= s1;
    end
  end

  // flow-through completes at stage one, pipeline at stage two
  sram_cmd_pkg::slot_s done;
  assign done = ft_n ? s2 : s1;

  logic [DATA_W-1:0] mem [DEPTH];
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge core_clk_i) begin
        if (run && done.valid && done.is_write && done.lanes[g]) begin
          mem[done.addr][g*LANE_W +: LANE_W] <= data_in_i[g*LANE_W +: LANE_W];
        end
      end
    end
  endgenerate

  // read data register: the next completing read replaces it
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      data_out_o <= '0;
    end else if (run && done.valid && !done.is_write) begin
      data_out_o <= mem[done.addr];
    end
  end

  // drive flag; stalls keep it, writes and sleep clear it
  logic drive_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drive_q <= 1'b0; // undriven from power-up
    end else if (asleep) begin
      drive_q <= 1'b0;
    end else if (run) begin
      drive_q <= done.valid && done.drive;
    end
  end
  // output enable pin overrides drive asynchronously of commands
  assign data_oe_o = drive_q && !oe_n && !asleep;

  // checks
  chk_hold_freezes: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cmd_i.hold_n |=> $stable(cur_addr_o) && $stable(idx))
    else $error("address moved on a held edge");

  chk_reset_quiet: assert property (@(posedge core_clk_i)
    !nrst_i |-> !data_oe_o)
    else $error("bus driven in reset");

  chk_load_addr: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    do_load |=> cur_addr_o == $past(addr_i))
    else $error("load did not take external address");

  chk_burst_wrap: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_step && idx == 2'h3) |=> cur_addr_o == base)
    else $error("burst did not wrap to start");

  chk_step_count: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    do_step |=> idx == $past(idx) + 2'h1)
    else $error("counter did not step");

  chk_linear_seq: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_step && !lin_n) |=> cur_addr_o[1:0] == $past(cur_addr_o[1:0]) + 2'h1)
    else $error("linear order broken");

  chk_desel_idle: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (run && !cmd_i.step_or_load && !sel_all) |=> op == sram_cmd_pkg::OP_DESEL)
    else $error("deselect not taken");

  chk_write_quiet: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (run && done.valid && done.is_write) |=> !data_oe_o)
    else $error("bus driven after write slot");

  sequence zz_held;
    (zz && !asleep) [*2];
  endsequence
  chk_sleep_entry: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    zz_held |=> asleep)
    else $error("sleep not entered in time");

  sequence zz_released;
    (!zz && asleep) [*2];
  endsequence
  chk_sleep_exit: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    zz_released |=> !asleep)
    else $error("sleep not left in time");

  chk_sleep_quiet: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    asleep |-> !data_oe_o)
    else $error("bus driven while asleep");

  chk_wrap_index: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_step && idx == 2'h3) |=> idx == 2'h0)
    else $error("access index did not wrap");

  chk_interleave_seq: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_step && lin_n) |=> cur_addr_o[1:0] == ($past(base[1:0]) ^ ($past(idx) + 2'h1)))
    else $error("interleaved order broken");

  chk_desel_stay: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (run && cmd_i.step_or_load && op == sram_cmd_pkg::OP_DESEL)
    |=> op == sram_cmd_pkg::OP_DESEL)
    else $error("continue left the deselect state");

  chk_read_slot: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_load && cmd_i.store_n) |=> s1.valid && !s1.is_write)
    else $error("read load not queued");

  chk_write_slot: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (do_load && !cmd_i.store_n) |=> s1.valid && s1.is_write && !s1.drive)
    else $error("write load not queued");

  chk_abort_lanes: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (access_now && is_wr_now && (&cmd_i.byte_write_n)) |=> s1.lanes == '0)
    else $error("write abort enabled a lane");

  chk_dummy_read: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (run && access_now && !is_wr_now && oe_n) |=> !s1.drive)
    else $error("dummy read marked for driving");

  // a held edge must neither launch nor drop the drive flag
  chk_stall_drive: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!run && !asleep) |=> $stable(drive_q))
    else $error("drive flag moved on a stall");

  sequence read_taken;
    run && access_now && !is_wr_now && !oe_n;
  endsequence
  // latency counts taken edges only, so both stages need run
  chk_pipe_latency: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ft_n && read_taken ##1 (run && ft_n) ##1 (run && ft_n)) |=> drive_q)
    else $error("pipeline read data not launched");

  chk_flow_latency: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!ft_n && read_taken ##1 (run && !ft_n)) |=> drive_q)
    else $error("flow-through read data not launched");

endmodule // sync_sram_command_burst

// file: host_cmd_model.sv
// host side model: hands write data to the sram two taken edges after the write command in pipeline mode, one in flow-through
// assumes the bench changes commands just after the falling edge
`timescale 1ns/100ps
module host_cmd_model (
  input wire logic core_clk_i,
  input wire sram_cmd_pkg::cmd_s cmd_i,
  input wire logic flowthru_n_i,
  input wire logic [sram_cmd_pkg::DATA_W-1:0] wdata_i,
  output logic [sram_cmd_pkg::DATA_W-1:0] data_o
);
  logic [sram_cmd_pkg::DATA_W-1:0] d1, d2;
  logic v1 = 1'b0, v2 = 1'b0;
  initial data_o = '0;
  // held edges do not move the data pipe, as the device is frozen too
  always @(posedge core_clk_i) if (!cmd_i.hold_n) begin
    d2 <= d1;
    v2 <= v1;
    d1 <= wdata_i;
    v1 <= !cmd_i.store_n;
  end
  // outside a write slot the line toggles, so stale data never passes for good
  // flow-through takes data one taken edge sooner
  always @(negedge core_clk_i) begin
    if (!flowthru_n_i) data_o <= v1 ? d1 : ~data_o;
    else data_o <= v2 ? d2 : ~data_o;
  end
endmodule // host_cmd_model

// file: sync_sram_command_burst_tb.sv
// self-checking bench: bursts of writes and reads, reads compared through a queue
// starts in pipeline mode, awake, high drive, then covers flow-through and sleep; the host model supplies late write data
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module sync_sram_command_burst_tb;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic oe_n = 1'b0;
  logic lin_n = 1'b0;
  logic ft_n = 1'b1;
  logic zz = 1'b0;
  logic asl;
  logic [15:0] cur, ax;
  logic axv = 1'b0;
  sram_cmd_pkg::cmd_s cmd = '1;
  logic [15:0] addr = '0;
  logic [15:0] a;
  logic [35:0] wd = '0;
  logic [35:0] din, dout, exp;
  logic [35:0] mem [65536];
  logic [35:0] q [$];
  logic oe, hd;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  initial forever #12.5 core_clk_i = ~core_clk_i;
  host_cmd_model hm_u (.core_clk_i(core_clk_i), .cmd_i(cmd), .flowthru_n_i(ft_n),
    .wdata_i(wd), .data_o(din));
  sync_sram_command_burst dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .cmd_i(cmd),
    .addr_i(addr), .output_on_n_i(oe_n), .linear_order_n_i(lin_n), .flowthru_n_i(ft_n),
    .drive_strength_sel_i(1'b0), .sleep_req_i(zz), .data_in_i(din), .data_out_o(dout),
    .data_oe_o(oe), .high_drive_o(hd), .asleep_o(asl), .cur_addr_o(cur));
  task automatic conclude;
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input logic ld, input logic h, input logic st, input logic [3:0] b,
    input logic sel, input logic [15:0] ad);
    @(negedge core_clk_i);
    if (axv) `CHK(cur, ax)
    axv = 1'b0;
    cmd.hold_n = h;
    cmd.step_or_load = !ld;
    cmd.store_n = st;
    cmd.byte_write_n = b;
    cmd.select_one_n = !sel;
    cmd.chip_sel2 = sel;
    cmd.select_three_n = !sel;
    addr = ad;
    wd = {4'($urandom), $urandom};
  endtask
  task automatic idle(input int n);
    repeat (n) step(1, 0, 1, 4'hF, 0, 16'h0);
  endtask
  // load plus n-1 continues; the tb tracks the burst address on its own
  task automatic burst(input logic w, input logic [15:0] s, input int n, input bit rnd);
    logic [15:0] x;
    logic [3:0] b;
    for (int i = 0; i < n; i++) begin
      x = {s[15:2], lin_n ? s[1:0] ^ 2'(i) : s[1:0] + 2'(i)};
      b = rnd ? (i == 1 ? 4'hF : 4'($urandom)) : 4'h0;
      if (w && i == 2) step(0, 1, 0, 4'h0, 1, 16'h0);
      step(i == 0, 0, !w, w ? b : 4'hF, 1, s);
      ax = x;
      axv = 1'b1;
      if (w) begin
        for (int g = 0; g < 4; g++) if (!b[g]) mem[x][g*9+:9] = wd[g*9+:9];
      end else if (!oe_n) q.push_back(mem[x]);
    end
  endtask
  // one result per driven read cycle; stray driving pops an unknown and fails
  always @(negedge core_clk_i) if (nrst_i && oe === 1'b1) begin
    exp = q.size() > 0 ? q.pop_front() : 'x;
    `CHK(dout, exp)
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      conclude;
    end
  end
  initial begin
    void'($urandom(32'h9E0F752F));
    repeat (16) @(negedge core_clk_i);
    nrst_i = 1'b1;
    idle(4);
    `CHK(hd, 1'b1)
    a = 16'($urandom);
    burst(1, a, 4, 0);
    idle(1);
    step(0, 0, 1, 4'hF, 0, 16'h0); // deselect continue only after a deselect
    idle(2);
    burst(1, a, 4, 1);
    idle(2);
    burst(0, a, 5, 0);
    idle(2);
    lin_n = 1'b1;
    idle(4);
    a = 16'($urandom);
    burst(1, a, 4, 0);
    idle(2);
    burst(0, a, 4, 0);
    oe_n = 1'b1;
    idle(4);
    burst(0, a, 2, 0);
    oe_n = 1'b0;
    idle(6);
    ft_n = 1'b0;
    idle(4);
    a = 16'($urandom);
    burst(1, a, 4, 1);
    idle(2);
    burst(0, a, 4, 0);
    idle(4);
    zz = 1'b1;
    idle(8);
    `CHK(asl, 1'b1)
    zz = 1'b0;
    idle(8);
    `CHK(asl, 1'b0)
    `CHK(q.size(), 0)
    conclude;
  end
endmodule // sync_sram_command_burst_tb
